//--- rtl/arf_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 40 MHz system clock, one aligned 32-bit word per register
// Notes:   definitions only
`ifndef ARF_REGS_SVH
`define ARF_REGS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ARF_OFF_CTRL_A    8'h00
`define ARF_OFF_CTRL_B    8'h04
`define ARF_OFF_CTRL_C    8'h08
`define ARF_OFF_RES_HIGH  8'h0c
`define ARF_OFF_RES_LOW   8'h10
`define ARF_OFF_IRQ_STAT  8'h14
`define ARF_OFF_IRQ_CLR   8'h18
`define ARF_OFF_IRQ_EN    8'h1c
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ARF_A_ON_BIT      0
`define ARF_A_GO_BIT      1
`define ARF_A_CHS_LSB     2
`define ARF_A_CHS_MSB     6
`define ARF_B_REF_LSB     0
`define ARF_B_REF_MSB     1
`define ARF_B_CLK_LSB     4
`define ARF_B_CLK_MSB     6
`define ARF_B_JUST_BIT    7
`define ARF_C_TRIG_LSB    4
`define ARF_C_TRIG_MSB    7
`define ARF_IRQ_DONE_BIT  0
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ARF_CTRL_A_RST    8'h00
`define ARF_CTRL_B_RST    8'h00
`define ARF_CTRL_C_RST    8'h00
`define ARF_IRQ_RST       8'h00
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ARF_CLK_MHZ       40
`define ARF_TAMP_NS       2000
`define ARF_TAMP_CYC      ((`ARF_TAMP_NS * `ARF_CLK_MHZ + 999) / 1000)
`define ARF_CONV_TICKS    4'd11
`define ARF_FRC_TC        7'd39
`endif

//--- rtl/arf_pkg.sv
// Purpose: shared types of the result formatter
// Assumes: nothing
// Notes:   constants live in arf_regs.svh
package arf_pkg;
	typedef enum logic {ARF_IDLE, ARF_CONV} arf_seq_state_t;
	typedef logic [9:0] arf_result_t;
endpackage : arf_pkg

//--- rtl/arf_conv_if.sv
// Purpose: carrier between register side and conversion sequencer
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
interface arf_conv_if;
	logic                start;
	logic                abort;
	logic [6:0]          div_tc;
	arf_pkg::arf_result_t sar_data;
	logic                done;
	logic                busy;
	arf_pkg::arf_result_t result;
	modport top (output start, abort, div_tc, sar_data, input done, busy, result);
	modport seq (input start, abort, div_tc, sar_data, output done, busy, result);
endinterface : arf_conv_if
`default_nettype wire

//--- rtl/arf_trig_edge.sv
// Purpose: auto-trigger source select and rising edge detect
// Assumes: sources synchronous to clk_sys_i
// Notes:   codes 1..10 select a source, 0 and 11..15 never fire
`timescale 1ns/10ps
`default_nettype none
module arf_trig_edge (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	// sources and selection
	input  wire logic [15:0] src_i,
	input  wire logic [3:0]  sel_i,
	// one-cycle start request
	output logic             fire_o
);
	function automatic logic src_valid(input logic [3:0] sel);
		src_valid = (sel != 4'h0) && (sel <= 4'ha);
	endfunction : src_valid

	logic       prev_q;
	logic [3:0] sel_q;
	logic       cur_w;

	// selected source level
	assign cur_w  = src_i[sel_i];
	// a change of selection must not look like an edge
	assign fire_o = src_valid(sel_i) && (sel_q == sel_i) && cur_w && !prev_q;

	// previous level of the selected source
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			prev_q <= 1'b0;
			sel_q  <= 4'h0;
		end else begin
			prev_q <= cur_w;
			sel_q  <= sel_i;
		end
	end
endmodule : arf_trig_edge
`default_nettype wire

//--- rtl/arf_conv_seq.sv
// Purpose: conversion sequencer paced by the conversion clock enable
// Assumes: converter core presents its code on sar_data by the last tick
// Notes:   result register has no reset on purpose
`timescale 1ns/10ps
`default_nettype none
module arf_conv_seq
	import arf_pkg::*;
(
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	// register side
	arf_conv_if.seq   cif
);
	`include "arf_regs.svh"

	arf_seq_state_t state_q;
	logic [6:0]     div_q;
	logic [3:0]     tad_q;
	logic           done_q;
	arf_result_t    result_q;
	logic           tick_w;
	logic           last_w;

	// conversion clock enable from the divider
	assign tick_w     = (div_q == cif.div_tc);
	assign last_w     = tick_w && (tad_q == `ARF_CONV_TICKS - 4'd1);
	assign cif.busy   = (state_q == ARF_CONV);
	assign cif.done   = done_q;
	assign cif.result = result_q;

	// state, divider and tick count
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_q <= ARF_IDLE;
			div_q   <= 7'h00;
			tad_q   <= 4'h0;
			done_q  <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				ARF_IDLE: begin
					div_q <= 7'h00;
					tad_q <= 4'h0;
					if (cif.start) state_q <= ARF_CONV;
				end
				ARF_CONV: begin
					if (cif.abort) begin
						state_q <= ARF_IDLE;
					end else if (last_w) begin
						state_q <= ARF_IDLE;
						done_q  <= 1'b1;
					end else if (tick_w) begin
						div_q <= 7'h00;
						tad_q <= tad_q + 4'd1;
					end else begin
						div_q <= div_q + 7'd1;
					end
				end
				default: state_q <= ARF_IDLE;
			endcase
		end
	end

	// code capture; no reset so power-up content stays unknown
	always_ff @(posedge clk_sys_i) begin
		if ((state_q == ARF_CONV) && !cif.abort && last_w) result_q <= cif.sar_data;
	end
endmodule : arf_conv_seq
`default_nettype wire

//--- rtl/arf_top.sv
// Purpose: control and result formatting around a 10-bit converter core
// Assumes: AHB-Lite single word transfers, inputs synchronous to clk_sys_i
// Notes:   writes take no wait state, reads take one
`timescale 1ns/10ps
`default_nettype none
module arf_top
	import arf_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	// ahb-lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// auto-trigger sources
	input  wire logic [15:0] trig_src_i,
	// converter core
	input  wire arf_pkg::arf_result_t sar_data_i,
	output logic             adc_enable_o,
	output logic             sar_sample_o,
	output logic             sar_convert_o,
	output logic      [4:0]  channel_select_o,
	output logic      [1:0]  pos_ref_select_o,
	// interrupt
	output logic             irq_o
);
	import arf_pkg::*;
	`include "arf_regs.svh"

	// ---------------------------------------------------------------
	// formatting
	// ---------------------------------------------------------------
	// returns {high byte, low byte} with unused bits zero
	function automatic logic [15:0] fmt_result(input arf_result_t r, input logic right);
		if (right) fmt_result = {6'h00, r};
		else       fmt_result = {r, 6'h00};
	endfunction : fmt_result

	// terminal count of the conversion clock divider
	function automatic logic [6:0] div_term(input logic [2:0] sel);
		case (sel)
			3'h0:    div_term = 7'd1;
			3'h1:    div_term = 7'd7;
			3'h2:    div_term = 7'd31;
			3'h4:    div_term = 7'd3;
			3'h5:    div_term = 7'd15;
			3'h6:    div_term = 7'd63;
			default: div_term = `ARF_FRC_TC;
		endcase
	endfunction : div_term

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0]  ctrl_a_q, ctrl_a_d;
	logic [7:0]  ctrl_b_q;
	logic [7:0]  ctrl_c_q;
	logic [7:0]  res_high_q, res_high_d;
	logic [7:0]  res_low_q, res_low_d;
	logic        irq_flag_q, irq_flag_d;
	logic [7:0]  irq_en_q;
	logic        dp_valid_q;
	logic        dp_write_q;
	logic        rd_done_q;
	logic [7:0]  dp_addr_q;
	logic [31:0] hrdata_q;

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	logic        addr_ph_w;
	logic        wr_w;
	logic        rd_w;
	logic        wr_a_w, wr_b_w, wr_c_w;
	logic        wr_hi_w, wr_lo_w, wr_clr_w, wr_en_w;
	logic [7:0]  wd_w;
	logic [7:0]  rd_mux_w;

	// word transfers only; other sizes pass as no-ops
	assign addr_ph_w = hsel_i && hready_i && htrans_i[1] && (hsize_i == 3'h2);
	assign wr_w      = dp_valid_q && dp_write_q;
	assign rd_w      = dp_valid_q && !dp_write_q;
	assign wd_w      = hwdata_i[7:0];
	assign wr_a_w    = wr_w && (dp_addr_q == `ARF_OFF_CTRL_A);
	assign wr_b_w    = wr_w && (dp_addr_q == `ARF_OFF_CTRL_B);
	assign wr_c_w    = wr_w && (dp_addr_q == `ARF_OFF_CTRL_C);
	assign wr_hi_w   = wr_w && (dp_addr_q == `ARF_OFF_RES_HIGH);
	assign wr_lo_w   = wr_w && (dp_addr_q == `ARF_OFF_RES_LOW);
	assign wr_clr_w  = wr_w && (dp_addr_q == `ARF_OFF_IRQ_CLR);
	assign wr_en_w   = wr_w && (dp_addr_q == `ARF_OFF_IRQ_EN);

	// read selection; unmapped and write-only offsets read zero
	assign rd_mux_w =
		(dp_addr_q == `ARF_OFF_CTRL_A)   ? ctrl_a_q :
		(dp_addr_q == `ARF_OFF_CTRL_B)   ? ctrl_b_q :
		(dp_addr_q == `ARF_OFF_CTRL_C)   ? ctrl_c_q :
		(dp_addr_q == `ARF_OFF_RES_HIGH) ? res_high_q :
		(dp_addr_q == `ARF_OFF_RES_LOW)  ? res_low_q :
		(dp_addr_q == `ARF_OFF_IRQ_STAT) ? {7'h00, irq_flag_q} :
		(dp_addr_q == `ARF_OFF_IRQ_EN)   ? irq_en_q : 8'h00;

	// one wait state on reads so the data comes from a flop
	assign hreadyout_o = !(rd_w && !rd_done_q);
	assign hresp_o     = 1'b0;
	assign hrdata_o    = hrdata_q;

	// address phase capture
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			dp_valid_q <= 1'b0;
			dp_write_q <= 1'b0;
			dp_addr_q  <= 8'h00;
		end else if (hready_i) begin
			dp_valid_q <= addr_ph_w;
			dp_write_q <= hwrite_i;
			dp_addr_q  <= haddr_i[7:0];
		end
	end

	// read data register
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rd_done_q <= 1'b0;
			hrdata_q  <= 32'h0000_0000;
		end else begin
			rd_done_q <= rd_w && !rd_done_q;
			if (rd_w && !rd_done_q) hrdata_q <= {24'h00_0000, rd_mux_w};
		end
	end

	// ---------------------------------------------------------------
	// control
	// ---------------------------------------------------------------
	arf_conv_if cif ();

	logic        on_d;
	logic        go_d;
	logic        go_w;
	logic        on_w;
	logic        trig_fire_w;
	logic [15:0] fmt_w;

	assign on_w = ctrl_a_q[`ARF_A_ON_BIT];
	assign go_w = ctrl_a_q[`ARF_A_GO_BIT];
	assign on_d = wr_a_w ? wd_w[`ARF_A_ON_BIT] : on_w;

	// go: off kills it, completion clears it, then software, then trigger
	always_comb begin
		go_d = go_w;
		if (!on_d)                   go_d = 1'b0;
		else if (cif.done)           go_d = 1'b0;
		else if (wr_a_w)             go_d = wd_w[`ARF_A_GO_BIT];
		else if (trig_fire_w && !go_w) go_d = 1'b1;
	end

	assign ctrl_a_d = {1'b0,
		wr_a_w ? wd_w[`ARF_A_CHS_MSB:`ARF_A_CHS_LSB] : ctrl_a_q[`ARF_A_CHS_MSB:`ARF_A_CHS_LSB],
		go_d, on_d};

	// control registers
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctrl_a_q <= `ARF_CTRL_A_RST;
			ctrl_b_q <= `ARF_CTRL_B_RST;
			ctrl_c_q <= `ARF_CTRL_C_RST;
		end else begin
			ctrl_a_q <= ctrl_a_d;
			if (wr_b_w) ctrl_b_q <= {wd_w[7:4], 2'b00, wd_w[1:0]};
			if (wr_c_w) ctrl_c_q <= {wd_w[7:4], 4'h0};
		end
	end

	// sequencer hookup; start waits out the done cycle to avoid a restart
	assign cif.start    = go_w && on_w && !cif.busy && !cif.done;
	assign cif.abort    = !go_w;
	assign cif.div_tc   = div_term(ctrl_b_q[`ARF_B_CLK_MSB:`ARF_B_CLK_LSB]);
	assign cif.sar_data = sar_data_i;

	arf_conv_seq u_seq (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.cif       (cif)
	);

	arf_trig_edge u_trig (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.src_i     (trig_src_i),
		.sel_i     (ctrl_c_q[`ARF_C_TRIG_MSB:`ARF_C_TRIG_LSB]),
		.fire_o    (trig_fire_w)
	);

	// ---------------------------------------------------------------
	// result bytes
	// ---------------------------------------------------------------
	assign fmt_w      = fmt_result(cif.result, ctrl_b_q[`ARF_B_JUST_BIT]);
	// hardware load beats a software write in the same cycle
	assign res_high_d = cif.done ? fmt_w[15:8] : wd_w;
	assign res_low_d  = cif.done ? fmt_w[7:0]  : wd_w;

	// no reset: unknown at power-up, kept over any later reset
	always_ff @(posedge clk_sys_i) begin
		if (cif.done || wr_hi_w) res_high_q <= res_high_d;
		if (cif.done || wr_lo_w) res_low_q  <= res_low_d;
	end

	// ---------------------------------------------------------------
	// interrupt
	// ---------------------------------------------------------------
	// set wins over a clear in the same cycle
	assign irq_flag_d = (irq_flag_q && !(wr_clr_w && wd_w[`ARF_IRQ_DONE_BIT])) || cif.done;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_flag_q <= 1'b0;
			irq_en_q   <= `ARF_IRQ_RST;
		end else begin
			irq_flag_q <= irq_flag_d;
			if (wr_en_w) irq_en_q <= {7'h00, wd_w[`ARF_IRQ_DONE_BIT]};
		end
	end

	assign irq_o = irq_flag_q && irq_en_q[`ARF_IRQ_DONE_BIT];

	// ---------------------------------------------------------------
	// converter core pins
	// ---------------------------------------------------------------
	// sampling resumes right after a conversion with no discharge step
	assign adc_enable_o     = on_w;
	assign sar_sample_o     = on_w && !cif.busy;
	assign sar_convert_o    = cif.busy;
	assign channel_select_o = ctrl_a_q[`ARF_A_CHS_MSB:`ARF_A_CHS_LSB];
	assign pos_ref_select_o = ctrl_b_q[`ARF_B_REF_MSB:`ARF_B_REF_LSB];

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_load_left;
		cif.done && !ctrl_b_q[`ARF_B_JUST_BIT];
	endsequence
	sequence s_load_right;
		cif.done && ctrl_b_q[`ARF_B_JUST_BIT];
	endsequence
	sequence s_finished;
		!go_w && irq_flag_q && !sar_convert_o;
	endsequence

	property p_left_fmt;
		s_load_left |=> ({res_high_q, res_low_q[7:6]} == $past(cif.result));
	endproperty
	a_left_fmt: assert property (p_left_fmt) else $error("left justified load wrong");

	property p_left_zero;
		s_load_left |=> (res_low_q[5:0] == 6'h00);
	endproperty
	a_left_zero: assert property (p_left_zero) else $error("low byte spare bits set");

	property p_right_zero;
		s_load_right |=> (res_high_q[7:2] == 6'h00);
	endproperty
	a_right_zero: assert property (p_right_zero) else $error("high byte spare bits set");

	property p_right_fmt;
		s_load_right |=> ({res_high_q[1:0], res_low_q} == $past(cif.result));
	endproperty
	a_right_fmt: assert property (p_right_fmt) else $error("right justified load wrong");

	property p_res_kept;
		!cif.done && !wr_hi_w && !wr_lo_w |=> $stable(res_high_q) && $stable(res_low_q);
	endproperty
	a_res_kept: assert property (p_res_kept) else $error("result bytes changed");

	property p_finish;
		cif.done |=> s_finished;
	endproperty
	a_finish: assert property (p_finish) else $error("completion not seen together");

	property p_go_held;
		go_w && on_w && !cif.done && !wr_a_w |=> go_w;
	endproperty
	a_go_held: assert property (p_go_held) else $error("go dropped early");

	property p_start;
		cif.start |=> sar_convert_o ##1 (sar_convert_o || !$past(go_w));
	endproperty
	a_start: assert property (p_start) else $error("conversion did not start");

	property p_off;
		!on_w |-> !go_w ##1 !sar_convert_o;
	endproperty
	a_off: assert property (p_off) else $error("converter ran while off");

	property p_trig;
		trig_fire_w && on_w && !go_w && !wr_a_w |=> go_w;
	endproperty
	a_trig: assert property (p_trig) else $error("trigger edge ignored");

	property p_resample;
		cif.done |-> sar_sample_o;
	endproperty
	a_resample: assert property (p_resample) else $error("sampling not resumed");
endmodule : arf_top
`default_nettype wire

//--- tb/adc_result_formatter_test.sv
// Purpose: self-checking bench for the converter result formatter
// Assumes: single 40 MHz clock, bus hready fed back from hreadyout
// Notes:   converter core code is driven by the bench directly
`timescale 1ns/10ps
`default_nettype none
`include "arf_regs.svh"
module adc_result_formatter_test;
	import arf_pkg::*;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	typedef struct {logic j; logic [9:0] sar; logic [7:0] hi; logic [7:0] lo;} arf_row_t;
	logic        clk_sys_i = 1'b0;
	logic        rst_n_i   = 1'b0;
	logic        hsel_i    = 1'b0;
	logic [31:0] haddr_i   = 32'h0;
	logic [1:0]  htrans_i  = 2'b00;
	logic        hwrite_i  = 1'b0;
	logic [2:0]  hsize_i   = 3'b010;
	logic [31:0] hwdata_i  = 32'h0;
	logic [31:0] hrdata_o;
	logic        hreadyout_o;
	logic        hresp_o;
	logic [15:0] trig_src_i = 16'h0;
	arf_result_t sar_data_i = 10'h0;
	logic        adc_enable_o;
	logic        sar_sample_o;
	logic        sar_convert_o;
	logic [4:0]  channel_select_o;
	logic [1:0]  pos_ref_select_o;
	logic        irq_o;
	int          n_errors = 0;
	int          checks_done = 0;
	arf_row_t    rows [7];
	// ---------------------------------------------------------------
	// clock and design
	// ---------------------------------------------------------------
	always #12.5 clk_sys_i = ~clk_sys_i;
	arf_top u_arf_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
		.hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .trig_src_i(trig_src_i),
		.sar_data_i(sar_data_i), .adc_enable_o(adc_enable_o), .sar_sample_o(sar_sample_o),
		.sar_convert_o(sar_convert_o), .channel_select_o(channel_select_o),
		.pos_ref_select_o(pos_ref_select_o), .irq_o(irq_o));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, seen);
			n_errors++;
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize
	// ready is taken mid-cycle, where the combinational hreadyout has settled
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		logic rdy;
		@(posedge clk_sys_i);
		hsel_i   <= 1'b1;
		haddr_i  <= {24'h0, a};
		htrans_i <= 2'b10;
		hwrite_i <= wr;
		hsize_i  <= 3'b010;
		rdy = 1'b0;
		while (rdy !== 1'b1) begin
			@(negedge clk_sys_i);
			rdy = hreadyout_o;
			@(posedge clk_sys_i);
		end
		htrans_i <= 2'b00;
		hsel_i   <= 1'b0;
		hwdata_i <= wd;
		rdy = 1'b0;
		while (rdy !== 1'b1) begin
			@(negedge clk_sys_i);
			rdy = hreadyout_o;
			rd  = hrdata_o;
			@(posedge clk_sys_i);
		end
	endtask : xfer
	// ends mid-cycle so outputs launched by the landing edge have settled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] x;
		xfer(1'b1, a, {24'h0, d}, x);
		@(negedge clk_sys_i);
	endtask : wr
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [31:0] x;
		xfer(1'b0, a, 32'h0, x);
		check(nm, x, {24'h0, e});
	endtask : rd_chk
	// polls the go bit with a bounded count; a hang shows as a mismatch
	task automatic wait_done();
		logic [31:0] x;
		for (int k = 0; k < 100; k++) begin
			xfer(1'b0, `ARF_OFF_CTRL_A, 32'h0, x);
			if (x[1] === 1'b0) break;
		end
		check("go_cleared", x & 32'h2, 32'h0);
	endtask : wait_done
	task automatic do_reset();
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		repeat (12) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
	endtask : do_reset
	// ---------------------------------------------------------------
	// watchdog
	// ---------------------------------------------------------------
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		n_errors++;
		summarize();
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rows = '{'{1'b0, 10'h3ff, 8'hff, 8'hc0}, '{1'b0, 10'h155, 8'h55, 8'h40},
			'{1'b0, 10'h2aa, 8'haa, 8'h80}, '{1'b0, 10'h000, 8'h00, 8'h00},
			'{1'b1, 10'h3ff, 8'h03, 8'hff}, '{1'b1, 10'h2aa, 8'h02, 8'haa},
			'{1'b1, 10'h155, 8'h01, 8'h55}};
		do_reset();
		wr(`ARF_OFF_IRQ_EN, 8'h01);
		// table rows: result bytes preloaded with ones so forced zeros show
		foreach (rows[i]) begin
			wr(`ARF_OFF_CTRL_B, {rows[i].j, 7'h0});
			wr(`ARF_OFF_RES_HIGH, 8'hff);
			wr(`ARF_OFF_RES_LOW, 8'h5a);
			rd_chk("res_low_rw", `ARF_OFF_RES_LOW, 8'h5a);
			wr(`ARF_OFF_RES_LOW, 8'hff);
			sar_data_i <= rows[i].sar;
			wr(`ARF_OFF_CTRL_A, 8'h05);
			check("sampling", {31'h0, sar_sample_o}, 32'h1);
			check("enable_high", {31'h0, adc_enable_o}, 32'h1);
			repeat (`ARF_TAMP_CYC) @(posedge clk_sys_i);
			wr(`ARF_OFF_CTRL_A, 8'h07);
			wait_done();
			rd_chk("flag_set", `ARF_OFF_IRQ_STAT, 8'h01);
			check("irq_high", {31'h0, irq_o}, 32'h1);
			check("resampling", {31'h0, sar_sample_o}, 32'h1);
			rd_chk("res_high", `ARF_OFF_RES_HIGH, rows[i].hi);
			rd_chk("res_low", `ARF_OFF_RES_LOW, rows[i].lo);
			wr(`ARF_OFF_IRQ_CLR, 8'h01);
			check("irq_cleared", {31'h0, irq_o}, 32'h0);
		end
		// second reset: controls return to zero, result bytes keep their value
		do_reset();
		rd_chk("ctrl_a_rst", `ARF_OFF_CTRL_A, 8'h00);
		rd_chk("ctrl_b_rst", `ARF_OFF_CTRL_B, 8'h00);
		rd_chk("ctrl_c_rst", `ARF_OFF_CTRL_C, 8'h00);
		rd_chk("irq_en_rst", `ARF_OFF_IRQ_EN, 8'h00);
		rd_chk("res_high_kept", `ARF_OFF_RES_HIGH, 8'h01);
		rd_chk("res_low_kept", `ARF_OFF_RES_LOW, 8'h55);
		// go with the converter off is refused
		wr(`ARF_OFF_CTRL_A, 8'h02);
		rd_chk("go_off_refused", `ARF_OFF_CTRL_A, 8'h00);
		check("enable_low", {31'h0, adc_enable_o}, 32'h0);
		// slow conversion aborted by turning the converter off
		wr(`ARF_OFF_CTRL_B, 8'h62);
		check("pos_ref", {30'h0, pos_ref_select_o}, 32'h2);
		sar_data_i <= 10'h0f0;
		wr(`ARF_OFF_CTRL_A, 8'h7f);
		rd_chk("go_held", `ARF_OFF_CTRL_A, 8'h7f);
		check("converting", {31'h0, sar_convert_o}, 32'h1);
		check("channel", {27'h0, channel_select_o}, 32'h1f);
		wr(`ARF_OFF_CTRL_A, 8'h00);
		repeat (800) @(posedge clk_sys_i);
		rd_chk("abort_no_flag", `ARF_OFF_IRQ_STAT, 8'h00);
		rd_chk("abort_res_kept", `ARF_OFF_RES_LOW, 8'h55);
		// auto trigger on every code, interrupt masked meanwhile
		wr(`ARF_OFF_CTRL_B, 8'h80);
		wr(`ARF_OFF_CTRL_A, 8'h01);
		for (int c = 0; c < 16; c++) begin
			wr(`ARF_OFF_CTRL_C, c[3:0] << 4);
			@(posedge clk_sys_i);
			trig_src_i <= 16'hffff;
			@(posedge clk_sys_i);
			trig_src_i <= 16'h0000;
			if (c >= 1 && c <= 10) begin
				wait_done();
				rd_chk("trig_flag", `ARF_OFF_IRQ_STAT, 8'h01);
				check("irq_masked", {31'h0, irq_o}, 32'h0);
			end else begin
				repeat (60) @(posedge clk_sys_i);
				rd_chk("no_trig_flag", `ARF_OFF_IRQ_STAT, 8'h00);
			end
			wr(`ARF_OFF_IRQ_CLR, 8'h01);
		end
		// unmapped offset and read-only status are left alone by writes
		wr(8'h40, 8'hff);
		rd_chk("unmapped", 8'h40, 8'h00);
		wr(`ARF_OFF_IRQ_STAT, 8'h01);
		rd_chk("status_ro", `ARF_OFF_IRQ_STAT, 8'h00);
		check("hresp_okay", {31'h0, hresp_o}, 32'h0);
		summarize();
	end
endmodule : adc_result_formatter_test
`default_nettype wire
